// File: common/fmx_pkg.sv
// constants, register map and state codes of the fm multiplex host control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package fmx_pkg;
   // serial addresses, sent lsb first while the enable pin is low
   localparam logic [7:0] ADDR_WRITE_REGS = 8'hFA;
   localparam logic [7:0] ADDR_READ_DATA = 8'hFB;
   localparam logic [7:0] ADDR_CRC_FEED = 8'hFC;
   localparam logic [7:0] ADDR_READ_REGS = 8'hFD;
   // write register addresses
   localparam logic [3:0] REG_ID_ERR = 4'h1;
   localparam logic [3:0] REG_BLOCK_PROT = 4'h2;
   localparam logic [3:0] REG_FRAME_PROT = 4'h3;
   localparam logic [3:0] REG_CONTROL_ONE = 4'h4;
   localparam logic [3:0] REG_CONTROL_TWO = 4'h5;
   // read register addresses
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_BLOCK_NUMBER = 4'h2;
   // reset values
   localparam logic [7:0] RST_ID_ERR = 8'h22;
   localparam logic [7:0] RST_BLOCK_PROT = 8'h17;
   localparam logic [7:0] RST_FRAME_PROT = 8'h17;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_BLOCK_NUMBER = 8'h00;
   // control one fields
   localparam int C1_GROUP_CLEAR = 7;
   localparam int C1_OUT_INTERLOCK = 6;
   localparam int C1_OUTPUT_ALL = 5;
   localparam int C1_SYNC_RESTART = 4;
   localparam int C1_CORR_HALT = 3;
   localparam int C1_VERT_HALT = 2;
   localparam int C1_REALTIME = 1;
   localparam int C1_FRAME_A = 0;
   // control two fields
   localparam int C2_RESERVED = 7;
   localparam int C2_BLOCK_CLEAR = 6;
   localparam int C2_GRANT_POL = 5;
   localparam int C2_REQ_POL = 4;
   localparam int C2_READY_TIMING = 3;
   localparam int C2_VERT_POLICY = 2;
   localparam int C2_DMA_STROBE = 1;
   localparam int C2_DMA_EN = 0;
   // status fields
   localparam int ST_VERT_DONE = 7;
   localparam int ST_GROUP_OK = 1;
   // serial frame lengths in bits
   localparam logic [8:0] WRITE_BITS = 9'h010;
   localparam logic [8:0] REGS_BITS = 9'h010;
   localparam logic [8:0] DATA_BITS = 9'h120;
   localparam logic [8:0] HEADER_BITS = 9'h010;
   localparam int PAYLOAD_BITS = 272;
   // group check, x^16 + x^12 + x^5 + 1
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_ZERO = 16'h0000;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [2:0] {
      ST_ADDR = 3'b000,
      ST_WRITE = 3'b001,
      ST_DATA = 3'b010,
      ST_REGS = 3'b011,
      ST_CRC = 3'b100,
      ST_IGNORE = 3'b101
   } fmx_state_e;
endpackage : fmx_pkg
`default_nettype wire

// File: hdl/fmx_host_ctrl.sv
// fm multiplex demodulator host side: serial registers, corrected data readout, group check
// assumes a demodulator core on ref_clk and a host on three asynchronous serial pins
// Operation
// - sync restart clears sync state, keeps limits
// - during restart no interrupt, output released
// - correction halt stops corrected output only
// - vertical halt gives first horizontal data only
// - realtime change drops sync after protection
// - control one bit 0 selects frame method
// - block sync clear resets block sync only
// - bits 5,4 set dma line polarity
// - bit 3 selects ready output timing
// - vertical slot policy drops or fills output
// - bit 0 enables dma, bit 1 strobe
// - register read gives status then block number
// - status word field order fixed
// - group check ok reads one after reset
// - block number word resets to zero
// - words update when interrupt falls
// - data read at most 288 bits, header first
// - payload from leading bit, no id code
// - one data read per interrupt, aborts harmless
// - group check bytes fed via address FCh
// - register write carries sixteen bits
// - group check polynomial, cleared by host
`timescale 1ns/100ps
`default_nettype none

module fmx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } fmx_fifo_s;
   fmx_fifo_s q;
   fmx_fifo_s d;
   logic push;
   logic pop;

   assign inReady = q.count != (AW+1)'(DEPTH);
   assign outValid = q.count != '0;
   assign outData = q.mem[q.rd];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = inData;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : fmx_fifo

module fmx_host_ctrl #(
   parameter int PAYLOAD_BITS = fmx_pkg::PAYLOAD_BITS,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic serialClockPin,
   input wire logic serialEnablePin,
   input wire logic serialInPin,
   input wire logic interfaceSelectPin,
   output logic serialOutPin,
   output logic serialOutEn,
   output logic intN,
   input wire logic newBlock,
   input wire logic [7:0] blockStatus,
   input wire logic [7:0] blockIndex,
   input wire logic blockVertSlot,
   input wire logic [PAYLOAD_BITS-1:0] blockPayload,
   output logic [7:0] idErrorLimit,
   output logic [7:0] blockProtect,
   output logic [7:0] frameProtect,
   output logic groupCheckClear,
   output logic outputInterlock,
   output logic outputAllData,
   output logic syncRestart,
   output logic correctionHalt,
   output logic verticalFixHalt,
   output logic realtimeBlockFlag,
   output logic frameMethodA,
   output logic blockSyncClear,
   output logic verticalOutputPolicy,
   output logic dmaGrantActiveHigh,
   output logic dmaRequestActiveHigh,
   output logic readyTimingTwo,
   output logic dmaUseGrant,
   output logic dmaEnable,
   output logic groupCheckOk,
   output logic crcOverrun
);
   typedef struct packed {
      logic [1:0] clS;
      logic [1:0] ceS;
      logic [1:0] diS;
      logic [1:0] spS;
      logic clPrev;
      logic cePrev;
      fmx_pkg::fmx_state_e state;
      logic [7:0] addr;
      logic [15:0] inShift;
      logic [8:0] cnt;
      logic doOut;
      logic doEn;
      logic intN;
      logic fresh;
      logic [7:0] idErr;
      logic [7:0] blockProt;
      logic [7:0] frameProt;
      logic [7:0] ctl1;
      logic [7:0] control_two;
      logic [4:0] dmaCfg;
      logic [7:0] stat;
      logic [7:0] blockNo;
      logic [PAYLOAD_BITS-1:0] payload;
      logic [15:0] crc;
      logic [7:0] crcByte;
      logic [3:0] crcBits;
      logic crcOk;
      logic overrun;
   } fmx_core_s;
   fmx_core_s q;
   fmx_core_s d;

   logic clRise;
   logic ceRise;
   logic ceFall;
   logic serialMode;
   logic acceptEv;
   logic vertEff;
   logic [8:0] outIdx;
   logic [8:0] payIdx;
   logic [7:0] statWord;
   logic serialBit;
   logic [7:0] rxByte;
   logic pushValid;
   logic pushReady;
   logic fifoValid;
   logic fifoTake;
   logic [7:0] fifoData;
   logic crcFb;

   assign clRise = q.clS[1] && !q.clPrev;
   assign ceRise = q.ceS[1] && !q.cePrev;
   assign ceFall = !q.ceS[1] && q.cePrev;
   assign serialMode = q.spS[1];
   // status with live group check result
   assign statWord = {q.stat[7:2], q.crcOk, q.stat[0]};
   // status first, block number next, payload from its leading bit
   assign outIdx = ceRise ? 9'h000 : q.cnt + 9'h001;
   assign payIdx = outIdx - fmx_pkg::HEADER_BITS;
   always_comb begin
      if (outIdx < 9'h008) begin
         serialBit = statWord[outIdx[2:0]];
      end else if (outIdx < fmx_pkg::HEADER_BITS) begin
         serialBit = q.blockNo[outIdx[2:0]];
      end else if (int'(payIdx) < PAYLOAD_BITS) begin
         serialBit = q.payload[PAYLOAD_BITS - 1 - int'(payIdx)];
      end else begin
         serialBit = 1'b0;
      end
   end
   assign rxByte = {q.diS[1], q.inShift[15:9]};
   // blocks withheld under correction halt or sync restart, or by the vertical slot policy
   assign vertEff = blockStatus[fmx_pkg::ST_VERT_DONE] && !q.ctl1[fmx_pkg::C1_VERT_HALT];
   assign acceptEv = newBlock && !q.ctl1[fmx_pkg::C1_CORR_HALT]
      && !q.ctl1[fmx_pkg::C1_SYNC_RESTART]
      && !(blockVertSlot && !vertEff && !q.control_two[fmx_pkg::C2_VERT_POLICY]);
   assign fifoTake = fifoValid && q.crcBits == 4'h0 && !q.ctl1[fmx_pkg::C1_GROUP_CLEAR];
   assign crcFb = q.crc[15] ^ q.crcByte[0];

   fmx_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_crc_fifo (
      .clk(ref_clk),
      .resetn(resetn),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(rxByte),
      .outValid(fifoValid),
      .outReady(fifoTake),
      .outData(fifoData)
   );

   always_comb begin
      d = q;
      pushValid = 1'b0;
      d.clS = {q.clS[0], serialClockPin};
      d.ceS = {q.ceS[0], serialEnablePin};
      d.diS = {q.diS[0], serialInPin};
      d.spS = {q.spS[0], interfaceSelectPin};
      d.clPrev = q.clS[1];
      d.cePrev = q.ceS[1];
      // parallel only settings
      d.dmaCfg = serialMode ? 5'h00 : {q.control_two[fmx_pkg::C2_GRANT_POL],
         q.control_two[fmx_pkg::C2_REQ_POL], q.control_two[fmx_pkg::C2_READY_TIMING],
         q.control_two[fmx_pkg::C2_DMA_STROBE], q.control_two[fmx_pkg::C2_DMA_EN]};
      if (acceptEv) begin
         d.stat = {vertEff, blockStatus[6:0]};
         d.blockNo = blockIndex;
         d.payload = blockPayload;
         d.intN = 1'b0;
         d.fresh = 1'b1;
      end
      if (ceFall || !serialMode) begin
         d.state = fmx_pkg::ST_ADDR;
         d.cnt = 9'h000;
         d.doEn = 1'b0;
      end else if (ceRise) begin
         d.cnt = 9'h000;
         unique case (q.addr)
            fmx_pkg::ADDR_WRITE_REGS: d.state = fmx_pkg::ST_WRITE;
            fmx_pkg::ADDR_CRC_FEED: d.state = fmx_pkg::ST_CRC;
            fmx_pkg::ADDR_READ_REGS: begin
               d.state = fmx_pkg::ST_REGS;
               d.doEn = 1'b1;
               d.doOut = serialBit;
            end
            fmx_pkg::ADDR_READ_DATA: begin
               if (q.fresh && !acceptEv) begin
                  d.state = fmx_pkg::ST_DATA;
                  d.fresh = 1'b0;
                  d.intN = 1'b1;
                  d.doEn = 1'b1;
                  d.doOut = serialBit;
               end else begin
                  d.state = fmx_pkg::ST_IGNORE;
               end
            end
            default: d.state = fmx_pkg::ST_IGNORE;
         endcase
      end else if (clRise) begin
         d.cnt = q.cnt + 9'h001;
         unique case (q.state)
            fmx_pkg::ST_ADDR: d.addr = {q.diS[1], q.addr[7:1]};
            fmx_pkg::ST_WRITE: begin
               d.inShift = {q.diS[1], q.inShift[15:1]};
               if (d.cnt == fmx_pkg::WRITE_BITS) begin
                  d.state = fmx_pkg::ST_IGNORE;
                  unique case (d.inShift[11:8])
                     fmx_pkg::REG_ID_ERR: d.idErr = d.inShift[7:0];
                     fmx_pkg::REG_BLOCK_PROT: d.blockProt = d.inShift[7:0];
                     fmx_pkg::REG_FRAME_PROT: d.frameProt = d.inShift[7:0];
                     fmx_pkg::REG_CONTROL_ONE: d.ctl1 = d.inShift[7:0];
                     fmx_pkg::REG_CONTROL_TWO: d.control_two = d.inShift[7:0];
                     default: d.state = fmx_pkg::ST_IGNORE;
                  endcase
               end
            end
            fmx_pkg::ST_CRC: begin
               d.inShift = {q.diS[1], q.inShift[15:1]};
               if (q.cnt[2:0] == 3'h7) begin
                  pushValid = 1'b1;
                  d.overrun = q.overrun || !pushReady;
               end
            end
            fmx_pkg::ST_DATA, fmx_pkg::ST_REGS: begin
               if (d.cnt == ((q.state == fmx_pkg::ST_DATA) ? fmx_pkg::DATA_BITS
                     : fmx_pkg::REGS_BITS)) begin
                  d.state = fmx_pkg::ST_IGNORE;
                  d.doEn = 1'b0;
               end else begin
                  d.doOut = serialBit;
               end
            end
            fmx_pkg::ST_IGNORE: d.cnt = q.cnt;
            default: d.state = fmx_pkg::ST_IGNORE;
         endcase
      end
      // restart keeps the interrupt high and the output released
      if (q.ctl1[fmx_pkg::C1_SYNC_RESTART]) begin
         d.intN = 1'b1;
         d.doEn = 1'b0;
      end
      // group check engine, one bit per clock, lsb first
      if (q.ctl1[fmx_pkg::C1_GROUP_CLEAR]) begin
         d.crc = fmx_pkg::CRC_ZERO;
         d.crcBits = 4'h0;
         d.overrun = pushValid && !pushReady;
      end else if (q.crcBits != 4'h0) begin
         d.crc = {q.crc[14:0], 1'b0} ^ (crcFb ? fmx_pkg::CRC_POLY : fmx_pkg::CRC_ZERO);
         d.crcByte = {1'b0, q.crcByte[7:1]};
         d.crcBits = q.crcBits - 4'h1;
      end else if (fifoTake) begin
         d.crcByte = fifoData;
         d.crcBits = fmx_pkg::BYTE_BITS;
      end
      d.crcOk = (d.crc == fmx_pkg::CRC_ZERO);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.state <= fmx_pkg::ST_ADDR;
         q.intN <= 1'b1;
         q.idErr <= fmx_pkg::RST_ID_ERR;
         q.blockProt <= fmx_pkg::RST_BLOCK_PROT;
         q.frameProt <= fmx_pkg::RST_FRAME_PROT;
         q.ctl1 <= fmx_pkg::RST_CONTROL;
         q.control_two <= fmx_pkg::RST_CONTROL;
         q.blockNo <= fmx_pkg::RST_BLOCK_NUMBER;
         q.crcOk <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign serialOutPin = q.doOut;
   assign serialOutEn = q.doEn;
   assign intN = q.intN;
   assign idErrorLimit = q.idErr;
   assign blockProtect = q.blockProt;
   assign frameProtect = q.frameProt;
   assign groupCheckClear = q.ctl1[fmx_pkg::C1_GROUP_CLEAR];
   assign outputInterlock = q.ctl1[fmx_pkg::C1_OUT_INTERLOCK];
   assign outputAllData = q.ctl1[fmx_pkg::C1_OUTPUT_ALL];
   assign syncRestart = q.ctl1[fmx_pkg::C1_SYNC_RESTART];
   assign correctionHalt = q.ctl1[fmx_pkg::C1_CORR_HALT];
   assign verticalFixHalt = q.ctl1[fmx_pkg::C1_VERT_HALT];
   assign realtimeBlockFlag = q.ctl1[fmx_pkg::C1_REALTIME];
   assign frameMethodA = q.ctl1[fmx_pkg::C1_FRAME_A];
   assign blockSyncClear = q.control_two[fmx_pkg::C2_BLOCK_CLEAR];
   assign verticalOutputPolicy = q.control_two[fmx_pkg::C2_VERT_POLICY];
   assign dmaGrantActiveHigh = q.dmaCfg[4];
   assign dmaRequestActiveHigh = q.dmaCfg[3];
   assign readyTimingTwo = q.dmaCfg[2];
   assign dmaUseGrant = q.dmaCfg[1];
   assign dmaEnable = q.dmaCfg[0];
   assign groupCheckOk = q.crcOk;
   assign crcOverrun = q.overrun;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_read_start(logic [7:0] a, logic c);
      ceRise && serialMode && q.addr == a && c;
   endsequence
   sequence s_data_go;
      s_read_start(fmx_pkg::ADDR_READ_DATA, q.fresh && !acceptEv);
   endsequence

   a_restart_quiet: assert property (syncRestart |=> intN && !serialOutEn)
      else $error("restart left interrupt or output active");
   a_halt_blocks: assert property (correctionHalt && newBlock |-> !acceptEv)
      else $error("block taken during correction halt");
   a_vert_halt_flag: assert property (verticalFixHalt && acceptEv |=> !q.stat[7])
      else $error("vertical done shown under vertical halt");
   a_policy_drop: assert property (newBlock && blockVertSlot && !vertEff
      && !verticalOutputPolicy |-> !acceptEv)
      else $error("vertical slot output without correction");
   a_update_at_fall: assert property (acceptEv |=> !intN && q.blockNo == $past(blockIndex))
      else $error("words not updated with interrupt fall");
   a_group_clear: assert property (groupCheckClear ##1 groupCheckClear |-> groupCheckOk)
      else $error("group check not clear");
   a_once_per_int: assert property (s_data_go |=> !q.fresh ##1 (!q.fresh || !intN))
      else $error("second data read allowed");
   a_stale_ignored: assert property (s_read_start(fmx_pkg::ADDR_READ_DATA, !q.fresh)
      |=> q.state == fmx_pkg::ST_IGNORE && !serialOutEn)
      else $error("stale data read served");
   a_abort_restart: assert property (ceFall |=> q.state == fmx_pkg::ST_ADDR && q.cnt == 9'h000)
      else $error("aborted read left pointer set");
   a_first_status: assert property (s_read_start(fmx_pkg::ADDR_READ_REGS, !syncRestart)
      |=> serialOutEn && serialOutPin == $past(statWord[0]))
      else $error("register read did not start with status lsb");
endmodule : fmx_host_ctrl
`default_nettype wire

// File: dv/fmx_host_model.sv
// host serial master model for the fm multiplex host control block
// assumes the block's serial pins, a 320 ns link clock and a pull-up on data out
`timescale 1ns/100ps
`default_nettype none
module fmx_host_model (
   input wire logic serialOutPin,
   input wire logic serialOutEn,
   output logic serialClockPin,
   output logic serialEnablePin,
   output logic serialInPin
);
   logic outWire;
   // released data out floats to the pull-up level
   assign outWire = serialOutEn ? serialOutPin : 1'b1;
   initial begin
      serialClockPin = 1'b0;
      serialEnablePin = 1'b0;
      serialInPin = 1'b0;
   end
   // address lsb first with enable low, then n bits; clock stands still between frames
   task automatic xfer(input logic [7:0] addr, input int n, input logic [287:0] din,
         output logic [287:0] dout);
      dout = {288{1'b1}};
      for (int i = 0; i < 8; i++) begin
         serialInPin = addr[i];
         #160 serialClockPin = 1'b1;
         #160 serialClockPin = 1'b0;
      end
      #160 serialEnablePin = 1'b1;
      #320;
      for (int i = 0; i < n; i++) begin
         serialInPin = din[i];
         #160 dout[i] = outWire;
         serialClockPin = 1'b1;
         #160 serialClockPin = 1'b0;
      end
      #160 serialEnablePin = 1'b0;
      // data in line is driven to the inverse of its last value
      serialInPin = ~serialInPin;
      #480;
   endtask : xfer
endmodule : fmx_host_model
`default_nettype wire

// File: dv/fmx_host_ctrl_bench.sv
// self-checking bench of the fm multiplex host control block
// assumes fmx_pkg, fmx_host_ctrl and the host model fmx_host_model
`timescale 1ns/100ps
`default_nettype none
module fmx_host_ctrl_bench;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic newBlock = 1'b0;
   logic [7:0] blockStatus = 8'h00;
   logic [7:0] blockIndex = 8'h00;
   logic blockVertSlot = 1'b0;
   logic [271:0] blockPayload = {17{16'hC3A5}};
   logic interfaceSelectPin = 1'b1;
   wire logic sck;
   wire logic sen;
   wire logic sin;
   logic sout;
   logic soutEn;
   logic intN;
   logic [7:0] idErr;
   logic [7:0] blkProt;
   logic [7:0] frmProt;
   wire logic [7:0] ctlOne;
   wire logic [1:0] ctlTwo;
   wire logic [4:0] dmaCfg;
   logic groupCheckOk;
   logic crcOverrun;
   int errorCnt = 0;
   int checkCount = 0;
   int enCnt = 0;
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (soutEn === 1'b1) enCnt <= enCnt + 1;
   fmx_host_model host (.serialOutPin(sout), .serialOutEn(soutEn), .serialClockPin(sck),
      .serialEnablePin(sen), .serialInPin(sin));
   fmx_host_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .serialClockPin(sck),
      .serialEnablePin(sen), .serialInPin(sin), .interfaceSelectPin(interfaceSelectPin),
      .serialOutPin(sout), .serialOutEn(soutEn), .intN(intN), .newBlock(newBlock),
      .blockStatus(blockStatus), .blockIndex(blockIndex), .blockVertSlot(blockVertSlot),
      .blockPayload(blockPayload), .idErrorLimit(idErr), .blockProtect(blkProt),
      .frameProtect(frmProt), .groupCheckClear(ctlOne[7]), .outputInterlock(ctlOne[6]),
      .outputAllData(ctlOne[5]), .syncRestart(ctlOne[4]), .correctionHalt(ctlOne[3]),
      .verticalFixHalt(ctlOne[2]), .realtimeBlockFlag(ctlOne[1]), .frameMethodA(ctlOne[0]),
      .blockSyncClear(ctlTwo[1]), .verticalOutputPolicy(ctlTwo[0]),
      .dmaGrantActiveHigh(dmaCfg[4]), .dmaRequestActiveHigh(dmaCfg[3]),
      .readyTimingTwo(dmaCfg[2]), .dmaUseGrant(dmaCfg[1]), .dmaEnable(dmaCfg[0]),
      .groupCheckOk(groupCheckOk), .crcOverrun(crcOverrun));
   task automatic chkBit(input logic got, input logic exp);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chkBit
   task automatic chkVal(input logic [287:0] got, input logic [287:0] exp);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : chkVal
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      logic [287:0] d;
      host.xfer(fmx_pkg::ADDR_WRITE_REGS, 16, {272'h0, 4'h0, a, v}, d);
   endtask : wr
   task automatic rdRegs(output logic [7:0] st, output logic [7:0] bn);
      logic [287:0] d;
      host.xfer(fmx_pkg::ADDR_READ_REGS, 16, 288'h0, d);
      st = d[7:0];
      bn = d[15:8];
   endtask : rdRegs
   task automatic give(input logic [7:0] st, input logic [7:0] idx);
      @(posedge ref_clk);
      #2 newBlock = 1'b1;
      blockStatus = st;
      blockIndex = idx;
      @(posedge ref_clk);
      #2 newBlock = 1'b0;
      repeat (2) @(posedge ref_clk);
      #2;
   endtask : give
   task automatic tReset;
      logic [7:0] st;
      logic [7:0] bn;
      chkBit(intN, 1'b1);
      chkBit(groupCheckOk, 1'b1);
      chkVal({idErr, blkProt, frmProt}, 24'h221717);
      chkVal({ctlOne, ctlTwo, dmaCfg}, 15'h0000);
      rdRegs(st, bn);
      chkVal(st, 8'h02);
      chkVal(bn, 8'h00);
   endtask : tReset
   task automatic tRead;
      logic [7:0] st;
      logic [7:0] bn;
      logic [287:0] d;
      logic [271:0] exp;
      int n;
      give(8'hE5, 8'hBD);
      chkBit(intN, 1'b0);
      rdRegs(st, bn);
      chkVal({bn, st}, 16'hBDE7);
      host.xfer(fmx_pkg::ADDR_READ_DATA, 288, 288'h0, d);
      chkBit(intN, 1'b1);
      chkVal(d[15:0], 16'hBDE7);
      for (int i = 0; i < 272; i++) exp[i] = blockPayload[271-i];
      chkVal(d[287:16], exp);
      n = enCnt;
      host.xfer(fmx_pkg::ADDR_READ_DATA, 16, 288'h0, d);
      chkVal(enCnt - n, 0);
   endtask : tRead
   task automatic tAbort;
      logic [287:0] d;
      give(8'h40, 8'h05);
      host.xfer(fmx_pkg::ADDR_READ_DATA, 20, 288'h0, d);
      chkVal(d[15:0], 16'h0542);
      chkBit(soutEn, 1'b0);
      give(8'h00, 8'h51);
      host.xfer(fmx_pkg::ADDR_READ_DATA, 288, 288'h0, d);
      chkVal(d[15:0], 16'h5102);
   endtask : tAbort
   task automatic tHalt;
      logic [7:0] st;
      logic [7:0] bn;
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h08);
      chkVal(ctlOne, 8'h08);
      give(8'h81, 8'h07);
      chkBit(intN, 1'b1);
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h04);
      give(8'hC1, 8'h09);
      chkBit(intN, 1'b0);
      rdRegs(st, bn);
      chkVal({bn, st}, 16'h0943);
   endtask : tHalt
   task automatic tRestart;
      logic [287:0] d;
      int n;
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h12);
      chkVal(ctlOne, 8'h12);
      chkBit(intN, 1'b1);
      chkVal({idErr, blkProt, frmProt}, 24'h221717);
      give(8'h20, 8'h11);
      chkBit(intN, 1'b1);
      n = enCnt;
      host.xfer(fmx_pkg::ADDR_READ_DATA, 288, 288'h0, d);
      chkVal(enCnt - n, 0);
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h00);
   endtask : tRestart
   task automatic tCrc;
      logic [287:0] d;
      logic [7:0] st;
      logic [7:0] bn;
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h80);
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h00);
      host.xfer(fmx_pkg::ADDR_CRC_FEED, 8, 288'h0, d);
      host.xfer(fmx_pkg::ADDR_CRC_FEED, 4, 288'hF, d);
      chkBit(groupCheckOk, 1'b1);
      host.xfer(fmx_pkg::ADDR_CRC_FEED, 8, 288'h5A, d);
      chkBit(groupCheckOk, 1'b0);
      rdRegs(st, bn);
      chkBit(st[1], 1'b0);
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h80);
      chkBit(groupCheckOk, 1'b1);
      chkBit(crcOverrun, 1'b0);
      wr(fmx_pkg::REG_CONTROL_ONE, 8'h00);
   endtask : tCrc
   task automatic tVert;
      logic [7:0] st;
      logic [7:0] bn;
      blockVertSlot = 1'b1;
      give(8'h60, 8'h21);
      chkBit(intN, 1'b1);
      wr(fmx_pkg::REG_CONTROL_TWO, 8'h04);
      give(8'h60, 8'h22);
      chkBit(intN, 1'b0);
      rdRegs(st, bn);
      chkVal({bn, st}, 16'h2262);
      blockVertSlot = 1'b0;
   endtask : tVert
   task automatic tPar;
      logic [7:0] v;
      for (int k = 0; k < 2; k++) begin
         v = (k == 1) ? 8'h2A : 8'h55;
         wr(fmx_pkg::REG_CONTROL_TWO, v);
         wr(4'h6, 8'hFF);
         wr(4'h0, 8'hFF);
         chkVal({ctlOne, ctlTwo, dmaCfg}, {8'h00, v[6], v[2], 5'h00});
         @(posedge ref_clk);
         #2 interfaceSelectPin = 1'b0;
         repeat (3) @(posedge ref_clk);
         #2;
         chkVal(dmaCfg, {v[5], v[4], v[3], v[1], v[0]});
         interfaceSelectPin = 1'b1;
         repeat (4) @(posedge ref_clk);
         #2;
      end
   endtask : tPar
   task automatic giveVerdict;
      if (errorCnt == 0 && checkCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : giveVerdict
   initial begin
      #2000000;
      errorCnt++;
      $display("ERROR %0t watchdog expired", $time);
      giveVerdict;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #2 resetn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #2;
      tReset;
      tRead;
      tAbort;
      tHalt;
      tRestart;
      tCrc;
      tVert;
      tPar;
      giveVerdict;
   end
endmodule : fmx_host_ctrl_bench
`default_nettype wire
